// file: hw/prc_defs.svh
// Constants for the clock ratio configuration block
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// Register indices; byte address is index times four
`define PRC_IDX_STATUS 10'h000
`define PRC_IDX_CONTROL 10'h001
`define PRC_IDX_READBACK 10'h0e2
`define PRC_ADDR_W 12

// Readback layout: setting bits 4..1 in 7:4, setting bit 0 in bit 3
`define PRC_RB_HI_LSB 4
`define PRC_RB_LO_BIT 3
`define PRC_RB_RESET 8'h00

// Status layout
`define PRC_ST_VALID_BIT 0
`define PRC_ST_RSVD_BIT 1
`define PRC_ST_OFF_BIT 2
`define PRC_ST_MPLL_BIT 3
`define PRC_ST_CPLL_BIT 4
`define PRC_ST_MEM_LSB 8
`define PRC_ST_CPU_LSB 12
`define PRC_ST_CODE_LSB 16

// Control layout
`define PRC_CTL_RESAMPLE_BIT 0

// Cycles in the delay state before the capture; one hold cycle follows both hard resets negated
`define PRC_SAMPLE_CYCLES 4

// Special ratio codes
`define PRC_CODE_SINGLE_BYPASS 5'h06
`define PRC_CODE_EARLY_ONLY 5'h07
`define PRC_CODE_DUAL_BYPASS 5'h1e
`define PRC_CODE_OFF 5'h1f

// Bus responses
`define PRC_RESP_OKAY 2'h0
`define PRC_RESP_SLVERR 2'h2

`endif

// file: hw/prc_pkg.sv
// Types shared by the clock ratio configuration block
package prc_pkg;

  // Decoded operating mode of the two PLLs
  typedef enum logic [2:0] {
    PRC_MODE_PLL,
    PRC_MODE_MEM_BYPASS,
    PRC_MODE_SINGLE_BYPASS,
    PRC_MODE_DUAL_BYPASS,
    PRC_MODE_OFF,
    PRC_MODE_RESERVED
  } prc_mode_t;

  // Source of a clock domain
  typedef enum logic [1:0] {
    PRC_SRC_PLL,
    PRC_SRC_PCI,
    PRC_SRC_BYPASS_IN,
    PRC_SRC_NONE
  } prc_src_t;

  // Sampling sequence
  typedef enum logic [1:0] {
    PRC_SEQ_HOLD,
    PRC_SEQ_DELAY,
    PRC_SEQ_DONE
  } prc_seq_t;

endpackage

// file: hw/prc_decode.sv
// Ratio code to multiplier and mode decoder
`timescale 1ns/10ps
`include "prc_defs.svh"

module prc_decode
  import prc_pkg::*;
#(
  parameter bit EARLY_REV = 1'b0
)
(
  input wire logic [4:0] code,
  output prc_mode_t mode,
  output logic [3:0] mem_mult_x2,
  output logic [3:0] cpu_mult_x2
);

  // Multipliers in half steps so 1.5 and 2.5 stay exact
  always_comb
  begin
    mode = PRC_MODE_PLL;
    mem_mult_x2 = 4'h0;
    cpu_mult_x2 = 4'h0;
    case (code)
      5'h00: begin mem_mult_x2 = 4'h6; cpu_mult_x2 = 4'h5; end
      5'h02: begin mem_mult_x2 = 4'h2; cpu_mult_x2 = 4'h9; end
      5'h03:
      begin
        mode = PRC_MODE_MEM_BYPASS;
        mem_mult_x2 = 4'h2;
        cpu_mult_x2 = 4'h4;
      end
      5'h04: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h4; end // RQ2
      `PRC_CODE_SINGLE_BYPASS:
      begin
        mode = PRC_MODE_SINGLE_BYPASS; // RQ3
        mem_mult_x2 = 4'h2;
        cpu_mult_x2 = 4'h2;
      end
      `PRC_CODE_EARLY_ONLY:
      begin
        // Only the earlier silicon has this setting
        if (EARLY_REV) // RQ9
        begin
          mode = PRC_MODE_MEM_BYPASS;
          mem_mult_x2 = 4'h2;
          cpu_mult_x2 = 4'h6;
        end
        else
          mode = PRC_MODE_RESERVED;
      end
      5'h08: begin mem_mult_x2 = 4'h2; cpu_mult_x2 = 4'h6; end // RQ2
      5'h09: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h4; end
      5'h0b: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h5; end
      5'h0c: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h5; end
      5'h0e: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h6; end
      5'h10: begin mem_mult_x2 = 4'h6; cpu_mult_x2 = 4'h4; end // RQ2
      5'h12: begin mem_mult_x2 = 4'h3; cpu_mult_x2 = 4'h4; end
      5'h14: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h7; end
      5'h16: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h8; end
      5'h17: begin mem_mult_x2 = 4'h8; cpu_mult_x2 = 4'h4; end
      5'h19: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h5; end
      5'h1a: begin mem_mult_x2 = 4'h2; cpu_mult_x2 = 4'h8; end
      5'h1b: begin mem_mult_x2 = 4'h4; cpu_mult_x2 = 4'h6; end
      5'h1c: begin mem_mult_x2 = 4'h3; cpu_mult_x2 = 4'h6; end
      5'h1d: begin mem_mult_x2 = 4'h3; cpu_mult_x2 = 4'h5; end
      `PRC_CODE_DUAL_BYPASS:
      begin
        mode = PRC_MODE_DUAL_BYPASS; // RQ4
        mem_mult_x2 = 4'h2;
        cpu_mult_x2 = 4'h2;
      end
      `PRC_CODE_OFF: mode = PRC_MODE_OFF; // RQ6
      default: mode = PRC_MODE_RESERVED;
    endcase
  end

endmodule

// file: hw/prc_axil.sv
// AXI4-Lite slave front end for the ratio registers
`timescale 1ns/10ps
`include "prc_defs.svh"

module prc_axil
  import prc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [9:0] wr_index,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [9:0] rd_index,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_full;
  logic w_full;

  // One write in flight; address and data may come in either order
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_en = aw_full && w_full && !s_axi_bvalid;

  // Write address holding
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      aw_full <= 1'b0;
      wr_index <= 10'h000;
    end
    else if (wr_en)
      aw_full <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full <= 1'b1;
      wr_index <= s_axi_awaddr[`PRC_ADDR_W-1:2];
    end
  end

  // Write data holding
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      w_full <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else if (wr_en)
      w_full <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
  end

  // Write response
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PRC_RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Reads answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_index = s_axi_araddr[`PRC_ADDR_W-1:2];

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PRC_RESP_OKAY;
    end
    else if (rd_en)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// file: hw/prc_top.sv
// Clock ratio strap sampling, decode and register access
// Functional notes
// RQ1 - One five-bit ratio setting sets both the memory and CPU multipliers.
// RQ2 - Codes decode per table, e.g. 00100 gives 2/2, 01000 1/3, 10000 3/2.
// RQ3 - Code 00110 runs the CPU from the PCI clock, memory PLL off, 1:1 bus.
// RQ4 - Dual bypass feeds logic from PCI and CPU from its own input, PLLs off.
// RQ5 - In dual bypass the board keeps both input clocks synchronized.
// RQ6 - Code 11111 stops all internal clocks and turns both PLLs off.
// RQ7 - The board must not strap any code that is not in the mapping; the bench straps 00001, flagged reserved.
// RQ8 - The sampled setting is readable in bits 7 to 4 of register 0xE2; the code puts setting bits 4..1 there and bit 0 in bit 3.
// RQ9 - Code 00111 is memory bypass with CPU times 3 on early silicon only.
// RQ10 - The board keeps the PCI reference clock at or below 66 MHz.
// RQ11 - Settings keep the memory PLL oscillator within 132 to 352 MHz.
// RQ12 - Settings keep the CPU PLL oscillator within 300 to 704 MHz.
// RQ13 - The straps are sampled a few clocks after both hard resets negate.
// RQ14 - The board holds the straps steady until sampling has completed.
`timescale 1ns/10ps
`include "prc_defs.svh"

module prc_top
  import prc_pkg::*;
#(
  parameter bit EARLY_REV = 1'b0,
  parameter int SAMPLE_CYCLES = `PRC_SAMPLE_CYCLES
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [4:0] pll_cfg,
  input wire logic cpu_hard_reset,
  input wire logic controller_hard_reset,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PRC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] mem_mult_x2,
  output logic [3:0] cpu_mult_x2,
  output logic mem_pll_on,
  output logic cpu_pll_on,
  output prc_src_t periph_clk_src,
  output prc_src_t cpu_clk_src,
  output logic clocks_stopped,
  output logic code_reserved,
  output logic config_valid
);

  localparam logic [2:0] CNT_LAST = 3'(SAMPLE_CYCLES - 1);

  prc_seq_t seq;
  logic [2:0] wait_cnt;
  logic [4:0] sampled_code;
  logic hard_any;
  logic capture;
  logic resample;
  prc_mode_t dec_mode;
  logic [3:0] dec_mem;
  logic [3:0] dec_cpu;
  logic wr_en;
  logic [9:0] wr_index;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [9:0] rd_index;
  logic [31:0] rd_data;
  logic rd_ok;

  // Either hard reset holds the straps unsampled
  assign hard_any = cpu_hard_reset || controller_hard_reset;
  assign capture = (seq == PRC_SEQ_DELAY) && !hard_any
    && (wait_cnt == CNT_LAST);
  assign resample = wr_en && (wr_index == `PRC_IDX_CONTROL) && wr_strb[0]
    && wr_data[`PRC_CTL_RESAMPLE_BIT];

  // Strap sampling sequence
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      seq <= PRC_SEQ_HOLD;
    else if (hard_any)
      seq <= PRC_SEQ_HOLD; // RQ13
    else
    begin
      unique case (seq)
        PRC_SEQ_HOLD: seq <= PRC_SEQ_DELAY; // RQ13
        PRC_SEQ_DELAY:
          if (capture)
            seq <= PRC_SEQ_DONE;
        PRC_SEQ_DONE:
          if (resample)
            seq <= PRC_SEQ_DELAY;
      endcase
    end
  end

  // Delay counter, restarted whenever the delay begins
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      wait_cnt <= 3'h0;
    else if (seq != PRC_SEQ_DELAY || hard_any)
      wait_cnt <= 3'h0;
    else if (!capture)
      wait_cnt <= wait_cnt + 3'h1;
  end

  // Decoder looks at the live straps; results latch only at capture
  prc_decode #(
    .EARLY_REV(EARLY_REV)
  ) u_decode (
    .code(pll_cfg),
    .mode(dec_mode),
    .mem_mult_x2(dec_mem),
    .cpu_mult_x2(dec_cpu)
  );

  // Captured setting and multipliers
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sampled_code <= 5'h00;
      mem_mult_x2 <= 4'h0;
      cpu_mult_x2 <= 4'h0;
    end
    else if (capture)
    begin
      sampled_code <= pll_cfg; // RQ13
      mem_mult_x2 <= dec_mem; // RQ1
      cpu_mult_x2 <= dec_cpu; // RQ1
    end
  end

  // Valid flag drops while a new sample is pending
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      config_valid <= 1'b0;
    else if (capture)
      config_valid <= 1'b1;
    else if (hard_any || resample)
      config_valid <= 1'b0;
  end

  // Clock steering from the decoded mode; clocks held off from reset until the first capture
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mem_pll_on <= 1'b0;
      cpu_pll_on <= 1'b0;
      periph_clk_src <= PRC_SRC_NONE;
      cpu_clk_src <= PRC_SRC_NONE;
      clocks_stopped <= 1'b1;
      code_reserved <= 1'b0;
    end
    else if (capture)
    begin
      code_reserved <= (dec_mode == PRC_MODE_RESERVED);
      unique case (dec_mode)
        PRC_MODE_PLL:
        begin
          mem_pll_on <= 1'b1; // RQ1
          cpu_pll_on <= 1'b1;
          periph_clk_src <= PRC_SRC_PLL;
          cpu_clk_src <= PRC_SRC_PLL;
          clocks_stopped <= 1'b0;
        end
        PRC_MODE_MEM_BYPASS:
        begin
          mem_pll_on <= 1'b0; // RQ9
          cpu_pll_on <= 1'b1;
          periph_clk_src <= PRC_SRC_PCI;
          cpu_clk_src <= PRC_SRC_PLL;
          clocks_stopped <= 1'b0;
        end
        PRC_MODE_SINGLE_BYPASS:
        begin
          // Processor runs straight from the PCI reference
          mem_pll_on <= 1'b0; // RQ3
          cpu_pll_on <= 1'b0;
          periph_clk_src <= PRC_SRC_PCI;
          cpu_clk_src <= PRC_SRC_PCI; // RQ3
          clocks_stopped <= 1'b0;
        end
        PRC_MODE_DUAL_BYPASS:
        begin
          // Relies on the two inputs being aligned by the board
          mem_pll_on <= 1'b0; // RQ4
          cpu_pll_on <= 1'b0; // RQ4
          periph_clk_src <= PRC_SRC_PCI;
          cpu_clk_src <= PRC_SRC_BYPASS_IN; // RQ4
          clocks_stopped <= 1'b0;
        end
        PRC_MODE_OFF, PRC_MODE_RESERVED:
        begin
          // A reserved code is parked like clock off: safest guess
          mem_pll_on <= 1'b0; // RQ6
          cpu_pll_on <= 1'b0;
          periph_clk_src <= PRC_SRC_NONE;
          cpu_clk_src <= PRC_SRC_NONE;
          clocks_stopped <= 1'b1; // RQ6
        end
        default:
        begin
          mem_pll_on <= 1'b0;
          cpu_pll_on <= 1'b0;
          periph_clk_src <= PRC_SRC_NONE;
          cpu_clk_src <= PRC_SRC_NONE;
          clocks_stopped <= 1'b1;
        end
      endcase
    end
  end

  // Register read mux
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (rd_index)
      `PRC_IDX_STATUS:
      begin
        rd_data[`PRC_ST_VALID_BIT] = config_valid;
        rd_data[`PRC_ST_RSVD_BIT] = code_reserved;
        rd_data[`PRC_ST_OFF_BIT] = clocks_stopped;
        rd_data[`PRC_ST_MPLL_BIT] = mem_pll_on;
        rd_data[`PRC_ST_CPLL_BIT] = cpu_pll_on;
        rd_data[`PRC_ST_MEM_LSB +: 4] = mem_mult_x2;
        rd_data[`PRC_ST_CPU_LSB +: 4] = cpu_mult_x2;
        rd_data[`PRC_ST_CODE_LSB +: 5] = sampled_code;
      end
      `PRC_IDX_CONTROL: rd_data = 32'h0000_0000;
      `PRC_IDX_READBACK:
      begin
        rd_data[`PRC_RB_HI_LSB +: 4] = sampled_code[4:1]; // RQ8
        rd_data[`PRC_RB_LO_BIT] = sampled_code[0];
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Only the control word accepts writes
  assign wr_ok = (wr_index == `PRC_IDX_CONTROL);

  prc_axil u_axil (
    .clock(clock),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_index(wr_index),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_index(rd_index),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Checks on the captured configuration
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_captured(logic [4:0] c);
    capture && pll_cfg == c ##1 config_valid;
  endsequence

  sequence s_rb_read;
    rd_en && rd_index == `PRC_IDX_READBACK;
  endsequence

  AST_SAMPLE_DELAY: assert property ( // RQ13
    $rose(config_valid) |->
      $past(seq) == PRC_SEQ_DELAY && !$past(hard_any)
      && $past(wait_cnt) == CNT_LAST && sampled_code == $past(pll_cfg))
    else $error("ratio setting captured at the wrong moment");

  AST_PLL_BOTH: assert property ( // RQ1
    capture && dec_mode == PRC_MODE_PLL |=>
      mem_pll_on && cpu_pll_on && mem_mult_x2 != 4'h0
      && cpu_mult_x2 != 4'h0 && !clocks_stopped)
    else $error("PLL mode did not set both multipliers");

  AST_DECODE_SAMPLES: assert property ( // RQ2
    (s_captured(5'h04) |-> mem_mult_x2 == 4'h4 && cpu_mult_x2 == 4'h4)
    and (s_captured(5'h08) |-> mem_mult_x2 == 4'h2 && cpu_mult_x2 == 4'h6)
    and (s_captured(5'h10) |-> mem_mult_x2 == 4'h6 && cpu_mult_x2 == 4'h4))
    else $error("multiplier decode mismatch");

  AST_SINGLE_BYPASS: assert property ( // RQ3
    s_captured(`PRC_CODE_SINGLE_BYPASS) |->
      cpu_clk_src == PRC_SRC_PCI && !mem_pll_on && mem_mult_x2 == 4'h2)
    else $error("single bypass steering wrong");

  AST_DUAL_BYPASS: assert property ( // RQ4
    s_captured(`PRC_CODE_DUAL_BYPASS) |->
      periph_clk_src == PRC_SRC_PCI && cpu_clk_src == PRC_SRC_BYPASS_IN
      && !mem_pll_on && !cpu_pll_on)
    else $error("dual bypass steering wrong");

  AST_CLOCK_OFF: assert property ( // RQ6
    s_captured(`PRC_CODE_OFF) |->
      clocks_stopped && !mem_pll_on && !cpu_pll_on
      ##1 clocks_stopped [*2])
    else $error("clock off mode left clocks running");

  AST_READBACK: assert property ( // RQ8
    s_rb_read ##1 s_axi_rvalid |->
      s_axi_rdata[7:4] == sampled_code[4:1] && s_axi_rresp == 2'h0)
    else $error("readback field wrong");

  AST_EARLY_ONLY: assert property ( // RQ9
    s_captured(`PRC_CODE_EARLY_ONLY) |->
      (EARLY_REV ? (!mem_pll_on && cpu_mult_x2 == 4'h6)
        : (code_reserved && clocks_stopped)))
    else $error("revision dependent code decoded wrongly");

endmodule

// file: test/prc_board.sv
// Board model: hard reset sequencing and ratio strap pins
`timescale 1ns/10ps

module prc_board
(
  input wire logic clock,
  input wire logic config_valid,
  output logic [4:0] pll_cfg,
  output logic cpu_hard_reset,
  output logic controller_hard_reset
);
  int settle = 0;

  // Pins pulled high and both resets held at power-up
  initial
  begin
    pll_cfg = 5'h1f;
    cpu_hard_reset = 1'b1;
    controller_hard_reset = 1'b1;
  end

  // Staggered release so only the later reset opens the window
  task automatic strap(input logic [4:0] code, input bit glitch);
    @(posedge clock);
    cpu_hard_reset <= 1'b1;
    controller_hard_reset <= 1'b1;
    pll_cfg <= code;
    repeat (3) @(posedge clock);
    cpu_hard_reset <= 1'b0;
    repeat (2) @(posedge clock);
    controller_hard_reset <= 1'b0;
    if (glitch)
    begin
      repeat (2) @(posedge clock);
      cpu_hard_reset <= 1'b1;
      @(posedge clock);
      cpu_hard_reset <= 1'b0;
    end
    settle = 0;
    while (!config_valid && settle < 40)
    begin
      @(posedge clock);
      #1;
      settle++;
    end
    // Released pins turn to debug use; never show the old strap
    pll_cfg <= ~code;
  endtask

  // Re-drive straps ahead of a software resample
  task automatic drive(input logic [4:0] code);
    @(posedge clock);
    pll_cfg <= code;
  endtask
endmodule

// file: test/pll_ratio_configuration_tb.sv
// Self-checking bench for the clock ratio configuration block
`timescale 1ns/10ps
`include "prc_defs.svh"

module pll_ratio_configuration_tb
  import prc_pkg::*;
;
  localparam logic [11:0] A_RB = {`PRC_IDX_READBACK, 2'b00};
  localparam logic [11:0] A_CTL = 12'h004;
  typedef struct {logic [4:0] c; logic [3:0] m; logic [3:0] p;} prc_row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  wire [4:0] pll_cfg;
  wire cpu_hard_reset;
  wire controller_hard_reset;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] mem_mult_x2, cpu_mult_x2, e_mem, e_cpu;
  logic mem_pll_on, cpu_pll_on, clocks_stopped, code_reserved;
  logic config_valid;
  prc_src_t periph_clk_src, cpu_clk_src;
  logic e_mpll, e_rsv;
  int error_cnt = 0;
  int cmp_count = 0;
  // Only listed codes, each with a reference range inside the VCO limits
  prc_row_t rows[18] = '{'{5'h00, 4'h6, 4'h5}, '{5'h02, 4'h2, 4'h9},
    '{5'h04, 4'h4, 4'h4}, '{5'h08, 4'h2, 4'h6}, '{5'h09, 4'h4, 4'h4},
    '{5'h0b, 4'h4, 4'h5}, '{5'h0c, 4'h4, 4'h5}, '{5'h0e, 4'h4, 4'h6},
    '{5'h10, 4'h6, 4'h4}, '{5'h12, 4'h3, 4'h4}, '{5'h14, 4'h4, 4'h7},
    '{5'h16, 4'h4, 4'h8}, '{5'h17, 4'h8, 4'h4}, '{5'h19, 4'h4, 4'h5},
    '{5'h1a, 4'h2, 4'h8}, '{5'h1b, 4'h4, 4'h6}, '{5'h1c, 4'h3, 4'h6},
    '{5'h1d, 4'h3, 4'h5}};

  // 10 MHz reference, far below the PCI input ceiling
  always #50 clock = ~clock;

  // Bypass input and reference share one clock, so they stay aligned
  prc_top DUT (.clock, .reset, .pll_cfg, .cpu_hard_reset,
    .controller_hard_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem_mult_x2, .cpu_mult_x2, .mem_pll_on, .cpu_pll_on, .periph_clk_src,
    .cpu_clk_src, .clocks_stopped, .code_reserved, .config_valid);

  // Early silicon variant shares every input with the main instance
  prc_top #(.EARLY_REV(1'b1)) DUT_EARLY (.clock, .reset, .pll_cfg,
    .cpu_hard_reset, .controller_hard_reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .mem_mult_x2(e_mem),
    .cpu_mult_x2(e_cpu), .mem_pll_on(e_mpll), .cpu_pll_on(),
    .periph_clk_src(), .cpu_clk_src(), .clocks_stopped(),
    .code_reserved(e_rsv), .config_valid());

  prc_board board (.clock, .config_valid, .pll_cfg, .cpu_hard_reset,
    .controller_hard_reset);

  task automatic test_done();
    $display("Checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    test_done();
  endtask

  task automatic chk(string nm, logic [33:0] exp, logic [33:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Capture with window length check; a stuck wait ends the run
  task automatic capture(input logic [4:0] code, input bit glitch);
    board.strap(code, glitch);
    chk("settle", 32'd5, board.settle);
    if (board.settle >= 40)
      test_done();
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 20)
      hang();
  endtask

  task automatic axr(input logic [11:0] a);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 20)
      hang();
  endtask

  // Flags packed as {mem_on, cpu_on, stopped, reserved, valid}
  task automatic special(input logic [4:0] code, input logic [4:0] fl,
    input prc_src_t p, input prc_src_t c, input logic [7:0] mc);
    capture(code, 1'b0);
    chk("flags", fl, {mem_pll_on, cpu_pll_on, clocks_stopped,
      code_reserved, config_valid});
    chk("src", {p, c}, {periph_clk_src, cpu_clk_src});
    chk("mult", mc, {mem_mult_x2, cpu_mult_x2});
  endtask

  initial
  begin
    int n;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk("rst", 5'b00100, {mem_pll_on, cpu_pll_on, clocks_stopped,
      code_reserved, config_valid});
    chk("rst_src", {PRC_SRC_NONE, PRC_SRC_NONE}, {periph_clk_src, cpu_clk_src});
    // Ordinary PLL codes from the table
    foreach (rows[i])
    begin
      capture(rows[i].c, 1'b0);
      chk("mem", rows[i].m, mem_mult_x2);
      chk("cpu", rows[i].p, cpu_mult_x2);
      chk("flags", 5'b11001, {mem_pll_on, cpu_pll_on, clocks_stopped,
        code_reserved, config_valid});
      axr(A_RB);
      chk("readback", {rows[i].c, 3'b000}, rd);
    end
    special(5'h03, 5'b01001, PRC_SRC_PCI, PRC_SRC_PLL, 8'h24);
    special(5'h06, 5'b00001, PRC_SRC_PCI, PRC_SRC_PCI, 8'h22);
    special(5'h1e, 5'b00001, PRC_SRC_PCI, PRC_SRC_BYPASS_IN, 8'h22);
    special(5'h1f, 5'b00101, PRC_SRC_NONE, PRC_SRC_NONE, 8'h00);
    special(5'h07, 5'b00111, PRC_SRC_NONE, PRC_SRC_NONE, 8'h00);
    chk("early", 10'h026, {e_mpll, e_rsv, e_mem, e_cpu});
    special(5'h01, 5'b00111, PRC_SRC_NONE, PRC_SRC_NONE, 8'h00);
    // Hard reset bounce inside the delay must restart it
    capture(5'h04, 1'b1);
    axr(12'h000);
    chk("status", 32'h0004_4419, rd);
    axr(12'h100);
    chk("unmapped", 34'h2_0000_0000, {rsp, rd});
    axw(A_RB, 32'h0000_00f0);
    chk("rb_wr", `PRC_RESP_SLVERR, rsp);
    axr(A_RB);
    chk("rb_kept", {2'h0, 32'h0000_0020}, {rsp, rd});
    axr(A_CTL);
    chk("ctl_rd", 34'h0, {rsp, rd});
    // Software resample picks up new strap levels
    board.drive(5'h10);
    axw(A_CTL, 32'h0000_0001);
    chk("ctl_wr", `PRC_RESP_OKAY, rsp);
    #1;
    chk("valid_drop", 1'b0, config_valid);
    for (n = 0; n < 20 && !config_valid; n++)
      @(posedge clock);
    if (n == 20)
      hang();
    #1;
    chk("resample", 8'h64, {mem_mult_x2, cpu_mult_x2});
    // Reset in mid-run parks every clock
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    #1;
    chk("rst2", 5'b00100, {mem_pll_on, cpu_pll_on, clocks_stopped,
      code_reserved, config_valid});
    test_done();
  end
endmodule
